/* sim/adc_clock_divider_and_power_down_tb.sv */
/*
 * Directed bench for the clock controller through its register port.
 * Assumes the pulse source partner and the bound checker.
 */
`default_nettype none

module adc_clock_divider_and_power_down_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst, pdp, fire, retune, align, fchg, tick, cclk, rdy, lock;
	logic [7:0] rdata, d;
	ckd_pkg::ckd_reg_req_t req;
	ckd_pkg::ckd_pwr_ctl_t pwr;
	int miscompares, n_checks, cyc, p, h, l0, l1, g, w1, w2;

	// Rate set high so the restorer can lock
	ckd_clock_ctrl #(.IN_CLK_HZ(40_000_000)) u_ckd_clock_ctrl (.clk(clk), .rst(rst),
		.reg_req(req), .reg_rdata(rdata), .power_down_pin(pdp), .align_pin(align),
		.freq_change(fchg), .conv_tick(tick), .conv_clk(cclk), .pwr_ctl(pwr),
		.conv_ready(rdy), .duty_cycle_restorer_locked(lock));
	ckd_pulse_src u_ckd_pulse_src (.clk(clk), .fire(fire), .retune(retune),
		.align_pin(align), .freq_change(fchg));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chkn(input int got, input int exp);
		n_checks++;
		if (got != exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [8:0] a, input logic [7:0] v);
		req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge clk);
		req.wr = 1'b0;
		@(negedge clk);
	endtask

	task automatic reg_rd(input logic [8:0] a, output logic [7:0] v);
		req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk);
		req.rd = 1'b0;
		@(negedge clk);
		v = rdata;
	endtask

	task automatic period(output int per, output int hi);
		int i;
		i = 0;
		while (tick !== 1'b1 && i < 20) begin
			@(negedge clk);
			i++;
		end
		per = 0;
		hi = 0;
		do begin
			hi += int'(cclk === 1'b1);
			per++;
			@(negedge clk);
		end while (tick !== 1'b1 && per < 20);
	endtask

	// Cycles from pulse to the first tick six or more cycles after it
	task automatic alat(output int c);
		fire <= 1'b1;
		@(negedge clk);
		fire <= 1'b0;
		c = 0;
		do begin
			@(negedge clk);
			c++;
		end while (!(c >= 6 && tick === 1'b1) && c < 30);
	endtask

	task automatic wake(output int w);
		w = 0;
		while (rdy !== 1'b1 && w < 300) begin
			@(negedge clk);
			w++;
		end
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end

	initial begin
		rst = 1'b1;
		pdp = 1'b0;
		fire = 1'b0;
		retune = 1'b0;
		req = '0;
		repeat (3) @(negedge clk);
		rst = 1'b0;
		// ------------------------------------------------------------
		// Registers, dividing ratios, restorer
		// ------------------------------------------------------------
		reg_rd(ckd_pkg::OFS_ALIGN_CTRL, d);
		chk(d, ckd_pkg::ALIGN_CTRL_RST);
		reg_rd(ckd_pkg::OFS_DUTY_CTRL, d);
		chk(d, ckd_pkg::DUTY_CTRL_RST);
		reg_wr(9'h0ff, 8'ha5);
		reg_rd(9'h0ff, d);
		chk(d, 8'h00);
		reg_wr(ckd_pkg::OFS_ALIGN_CTRL, 8'h06);
		reg_rd(ckd_pkg::OFS_ALIGN_CTRL, d);
		chk(d, 8'h06);
		for (int n = 1; n <= 8; n++) begin
			reg_wr(ckd_pkg::OFS_DIV_RATIO, 8'(n - 1));
			repeat (70) @(negedge clk);
			period(p, h);
			chkn(p, n);
			chkn(h, (n + 1) / 2);
		end
		reg_wr(ckd_pkg::OFS_DUTY_CTRL, 8'h00);
		reg_wr(ckd_pkg::OFS_DIV_RATIO, 8'h04);
		repeat (70) @(negedge clk);
		period(p, h);
		chkn(h, 3);
		reg_wr(ckd_pkg::OFS_DIV_RATIO, 8'h00);
		reg_rd(ckd_pkg::OFS_CLK_STATUS, d);
		chk({7'h00, d[0]}, 8'h00);
		reg_wr(ckd_pkg::OFS_DUTY_CTRL, 8'h01);
		reg_wr(ckd_pkg::OFS_DIV_RATIO, 8'h03);
		repeat (20) @(negedge clk);
		retune <= 1'b1;
		@(negedge clk);
		retune <= 1'b0;
		// Let the rate step reach the loop before timing a period
		repeat (2) @(negedge clk);
		period(p, h);
		chkn(h, 1);
		reg_rd(ckd_pkg::OFS_CLK_STATUS, d);
		chk({7'h00, d[1]}, 8'h00);
		chk({7'h00, lock}, 8'h00);
		repeat (70) @(negedge clk);
		reg_rd(ckd_pkg::OFS_CLK_STATUS, d);
		chk({7'h00, d[1]}, 8'h01);
		chk({7'h00, lock}, 8'h01);
		// ------------------------------------------------------------
		// Alignment, then power states
		// ------------------------------------------------------------
		reg_wr(ckd_pkg::OFS_DIV_RATIO, 8'h07);
		reg_wr(ckd_pkg::OFS_ALIGN_CTRL, 8'h02);
		repeat (20) @(negedge clk);
		alat(l0);
		// Gap puts the next pulse 3 off the old phase, so a miss shows
		g = 8 - ((l0 + 1) % 8) + 3;
		repeat (g) @(negedge clk);
		alat(l1);
		chkn(l1, l0);
		reg_wr(ckd_pkg::OFS_ALIGN_CTRL, 8'h06);
		alat(l1);
		chkn(l1, l0);
		repeat (g) @(negedge clk);
		alat(l1);
		chkn(int'(l1 != l0), 1);
		pdp = 1'b1;
		repeat (5) @(negedge clk);
		chk({3'h0, pwr}, 8'h00);
		chk({6'h00, rdy, tick}, 8'h00);
		repeat (35) @(negedge clk);
		pdp = 1'b0;
		wake(w1);
		chk({7'h00, rdy}, 8'h01);
		reg_wr(ckd_pkg::OFS_POWER_MODE, 8'h01);
		pdp = 1'b1;
		repeat (4) @(negedge clk);
		reg_wr(ckd_pkg::OFS_POWER_MODE, 8'h00);
		repeat (3) @(negedge clk);
		chk({3'h0, pwr}, 8'h00);
		repeat (190) @(negedge clk);
		pdp = 1'b0;
		wake(w2);
		chkn(int'(w2 > w1), 1);
		reg_wr(ckd_pkg::OFS_POWER_MODE, 8'h02);
		repeat (3) @(negedge clk);
		chk({3'h0, pwr}, 8'h18);
		repeat (200) @(negedge clk);
		reg_wr(ckd_pkg::OFS_POWER_MODE, 8'h00);
		wake(w1);
		chkn(int'(w1 < w2), 1);
		wrap_up();
	end
endmodule

`default_nettype wire

/* sim/ckd_checker.sv */
/*
 * Port checks for the clock controller.
 * Assumes one clock domain; bound onto every instance of the top.
 */
`default_nettype none

module ckd_checker (
	input wire logic clk,
	input wire logic rst,
	input wire ckd_pkg::ckd_reg_req_t reg_req,
	input wire logic [7:0] reg_rdata,
	input wire logic power_down_pin,
	input wire logic align_pin,
	input wire logic freq_change,
	input wire logic conv_tick,
	input wire logic conv_clk,
	input wire ckd_pkg::ckd_pwr_ctl_t pwr_ctl,
	input wire logic conv_ready,
	input wire logic duty_cycle_restorer_locked
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// ------------------------------------------------------------
	// Cycles since last rate step, saturating
	// ------------------------------------------------------------
	logic [4:0] since_ff;
	always_ff @(posedge clk) begin
		if (rst || freq_change) begin
			since_ff <= 5'h00;
		end else if (since_ff != 5'h1f) begin
			since_ff <= since_ff + 5'h01;
		end
	end

	chk_pin_down: assert property (power_down_pin [*5] |-> pwr_ctl == '0)
		else $error("pin held high but not powered down");
	chk_off_all: assert property (!pwr_ctl.ref_on |-> pwr_ctl == '0)
		else $error("partial shutdown");
	chk_standby_ref: assert property (pwr_ctl.ref_on && !pwr_ctl.bias_on |->
		pwr_ctl.ref_buf_on && !pwr_ctl.clock_on && !pwr_ctl.data_out_en)
		else $error("standby powers wrong blocks");
	chk_drv_ready: assert property (pwr_ctl.data_out_en |-> conv_ready && (&pwr_ctl))
		else $error("drivers on outside normal run");
	chk_clk_gated: assert property (!pwr_ctl.clock_on [*2] |-> !conv_tick && !conv_clk)
		else $error("divider runs with clock off");
	chk_rise_tick: assert property ($rose(conv_clk) |-> conv_tick)
		else $error("divided clock rose off period start");
	chk_relock_min: assert property (duty_cycle_restorer_locked |-> since_ff >= 5'h0f)
		else $error("restorer relocked too soon");
	chk_relock_hold: assert property (freq_change |=> !duty_cycle_restorer_locked [*8])
		else $error("restorer locked during relock wait");
	chk_rdata_hold: assert property (!reg_req.rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");
endmodule

bind ckd_clock_ctrl ckd_checker u_ckd_checker (.clk(clk), .rst(rst), .reg_req(reg_req),
	.reg_rdata(reg_rdata), .power_down_pin(power_down_pin), .align_pin(align_pin),
	.freq_change(freq_change), .conv_tick(conv_tick), .conv_clk(conv_clk),
	.pwr_ctl(pwr_ctl), .conv_ready(conv_ready),
	.duty_cycle_restorer_locked(duty_cycle_restorer_locked));

`default_nettype wire

/* sim/ckd_pulse_src.sv */
/*
 * Far side: alignment pulse driver and input rate monitor.
 * Assumes bench requests change by non-blocking assignment at the falling edge.
 */
`default_nettype none

module ckd_pulse_src (
	input wire logic clk,
	input wire logic fire,
	input wire logic retune,
	output var logic align_pin,
	output var logic freq_change
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] hold_ff;

	initial begin
		align_pin = 1'b0;
		freq_change = 1'b0;
		hold_ff = 2'h0;
	end

	// Four clocks high: long enough for the pin synchroniser
	always @(negedge clk) begin
		hold_ff <= fire ? 2'h3 : hold_ff - {1'b0, hold_ff != 2'h0};
		align_pin <= fire || hold_ff != 2'h0;
		freq_change <= retune;
	end
endmodule

`default_nettype wire

/* verilog/ckd_clock_ctrl.sv */
/*
 * Clock divider, alignment, duty restorer and power-state control.
 * Assumes clk is the undivided input clock, register requests come from the
 * serial control port on clk, and freq_change comes from a rate monitor on clk.
 */
`default_nettype none

module ckd_clock_ctrl #(
	parameter int IN_CLK_HZ = ckd_pkg::CLK_HZ
) (
	input wire logic clk,
	input wire logic rst,
	input wire ckd_pkg::ckd_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic power_down_pin,
	input wire logic align_pin,
	input wire logic freq_change,
	output logic conv_tick,
	output logic conv_clk,
	output ckd_pkg::ckd_pwr_ctl_t pwr_ctl,
	output logic conv_ready,
	output logic duty_cycle_restorer_locked
);

	// Relock wait scaled to the real input rate, rounded up
	localparam int CLK_MHZ = (IN_CLK_HZ + 999_999) / 1_000_000;
	localparam int RELOCK_N = (ckd_pkg::RELOCK_MIN_NS * CLK_MHZ + 999) / 1000;

	// ------------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------------
	if (IN_CLK_HZ <= 0) begin : g_bad_clk
		$error("IN_CLK_HZ must be positive");
	end
	if (RELOCK_N >= (1 << ckd_pkg::RELOCK_W)) begin : g_bad_relock
		$error("Relock count does not fit its counter");
	end

	// Restorer loop cannot run on a slow clock
	localparam logic RATE_OK = (IN_CLK_HZ >= ckd_pkg::RESTORER_MIN_HZ);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [7:0] align_ctrl;
		logic [2:0] ratio_m1;
		logic [7:0] duty_ctrl;
		logic [1:0] power_mode;
		logic armed;
		logic align_prev;
		logic [ckd_pkg::RELOCK_W-1:0] relock_cnt;
		ckd_pkg::ckd_pwr_state_t ps;
		logic [ckd_pkg::DOWN_CNT_W-1:0] down_cnt;
		logic [ckd_pkg::DOWN_CNT_W-1:0] wake_cnt;
		ckd_pkg::ckd_pwr_ctl_t pwr;
		logic ready;
		logic [7:0] rdata;
	} ckd_ctrl_st_t;

	ckd_ctrl_st_t st_ff;
	ckd_ctrl_st_t nxt_st;

	logic [1:0] pins_s;
	logic pd_pin_s;
	logic align_s;
	logic wr_align;
	logic wr_ratio;
	logic align_pulse;
	logic align_take;
	logic restorer_active;
	logic restorer_locked;
	logic any_pd;
	logic stby_req;
	logic [7:0] status;

	function automatic logic hit(input logic [ckd_pkg::REG_AW-1:0] a,
		input logic [ckd_pkg::REG_AW-1:0] ofs);
		hit = (a == ofs);
	endfunction

	function automatic ckd_pkg::ckd_pwr_ctl_t pwr_for(input ckd_pkg::ckd_pwr_state_t s);
		ckd_pkg::ckd_pwr_ctl_t p;
		p = '0;
		case (s)
			ckd_pkg::PS_RUN: begin
				p = '1;
			end
			ckd_pkg::PS_STANDBY: begin
				// Reference kept alive for a quick return
				p.ref_on = 1'b1;
				p.ref_buf_on = 1'b1;
			end
			ckd_pkg::PS_WAKE: begin
				// Drivers stay off until recharge completes
				p = '1;
				p.data_out_en = 1'b0;
			end
			default: begin
				// Everything off, drivers high-impedance
				p = '0;
			end
		endcase
		return p;
	endfunction

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	ckd_sync #(
		.W(2)
	) u_sync (
		.clk(clk),
		.rst(rst),
		.din({align_pin, power_down_pin}),
		.dout(pins_s)
	);

	assign pd_pin_s = pins_s[0];
	assign align_s = pins_s[1];

	// ------------------------------------------------------------------
	// Divider
	// ------------------------------------------------------------------
	ckd_divider u_div (
		.clk(clk),
		.rst(rst),
		.run(st_ff.pwr.clock_on),
		.ratio_m1(st_ff.ratio_m1),
		.restore_on(restorer_locked),
		.align(align_take),
		.conv_tick(conv_tick),
		.conv_clk(conv_clk)
	);

	// ------------------------------------------------------------------
	// Combinational decode
	// ------------------------------------------------------------------
	always_comb begin
		wr_align = reg_req.wr && hit(reg_req.addr, ckd_pkg::OFS_ALIGN_CTRL);
		wr_ratio = reg_req.wr && hit(reg_req.addr, ckd_pkg::OFS_DIV_RATIO);
		// Sampled on the undivided clock, rising transition only
		align_pulse = align_s && !st_ff.align_prev;
		align_take = 1'b0;
		if (align_pulse && st_ff.align_ctrl[ckd_pkg::ALIGN_EN_BIT] && st_ff.pwr.clock_on) begin
			// Every pulse, or only the armed one
			align_take = !st_ff.align_ctrl[ckd_pkg::ALIGN_FIRST_BIT] || st_ff.armed;
		end
		// Any ratio above 1 overrides the enable bit
		restorer_active = RATE_OK &&
			(st_ff.duty_ctrl[ckd_pkg::DUTY_EN_BIT] || (st_ff.ratio_m1 != 3'h0));
		restorer_locked = restorer_active && (st_ff.relock_cnt == '0);
		any_pd = pd_pin_s || (st_ff.power_mode == ckd_pkg::PM_DOWN);
		stby_req = (st_ff.power_mode == ckd_pkg::PM_STANDBY);
		status = {2'h0, st_ff.ready, st_ff.armed, (st_ff.ps == ckd_pkg::PS_STANDBY),
			(st_ff.ps == ckd_pkg::PS_DOWN), restorer_locked, restorer_active};
	end

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.align_prev = align_s;

		// Register writes
		if (wr_align) begin
			nxt_st.align_ctrl = reg_req.wdata;
		end
		if (wr_ratio) begin
			nxt_st.ratio_m1 = reg_req.wdata[2:0];
		end
		if (reg_req.wr && hit(reg_req.addr, ckd_pkg::OFS_DUTY_CTRL)) begin
			nxt_st.duty_ctrl = reg_req.wdata;
		end
		if (reg_req.wr && hit(reg_req.addr, ckd_pkg::OFS_POWER_MODE)) begin
			nxt_st.power_mode = reg_req.wdata[1:0];
		end

		// Arming: a write in the same cycle as a honoured pulse re-arms
		if (wr_align) begin
			nxt_st.armed = 1'b1;
		end else if (align_take) begin
			nxt_st.armed = 1'b0;
		end

		// Relock interval after any rate change or clock restart
		if (freq_change || !st_ff.pwr.clock_on || !restorer_active ||
			(wr_ratio && (reg_req.wdata[2:0] != st_ff.ratio_m1))) begin
			nxt_st.relock_cnt = ckd_pkg::RELOCK_W'(RELOCK_N);
		end else if (st_ff.relock_cnt != '0) begin
			nxt_st.relock_cnt = st_ff.relock_cnt - 1'b1;
		end

		// Power-state machine
		case (st_ff.ps)
			ckd_pkg::PS_RUN: begin
				nxt_st.down_cnt = '0;
				if (any_pd) begin
					nxt_st.ps = ckd_pkg::PS_DOWN;
				end else if (stby_req) begin
					nxt_st.ps = ckd_pkg::PS_STANDBY;
				end
			end
			ckd_pkg::PS_DOWN, ckd_pkg::PS_STANDBY: begin
				// Time spent down, saturating
				if (st_ff.down_cnt != '1) begin
					nxt_st.down_cnt = st_ff.down_cnt + 1'b1;
				end
				if (any_pd) begin
					nxt_st.ps = ckd_pkg::PS_DOWN;
				end else if (stby_req) begin
					nxt_st.ps = ckd_pkg::PS_STANDBY;
				end else begin
					// Leave only when neither request stands
					nxt_st.ps = ckd_pkg::PS_WAKE;
					// Recharge time follows time down standby is shorter
					if (st_ff.ps == ckd_pkg::PS_STANDBY) begin
						nxt_st.wake_cnt = st_ff.down_cnt >> ckd_pkg::WAKE_SHIFT_STANDBY;
					end else begin
						nxt_st.wake_cnt = st_ff.down_cnt >> ckd_pkg::WAKE_SHIFT_DOWN;
					end
				end
			end
			ckd_pkg::PS_WAKE: begin
				if (any_pd) begin
					nxt_st.ps = ckd_pkg::PS_DOWN;
					nxt_st.down_cnt = '0;
				end else if (stby_req) begin
					nxt_st.ps = ckd_pkg::PS_STANDBY;
					nxt_st.down_cnt = '0;
				end else if (st_ff.wake_cnt == '0) begin
					nxt_st.ps = ckd_pkg::PS_RUN;
				end else begin
					nxt_st.wake_cnt = st_ff.wake_cnt - 1'b1;
				end
			end
			default: begin
				nxt_st.ps = ckd_pkg::PS_DOWN;
			end
		endcase
		nxt_st.pwr = pwr_for(nxt_st.ps);
		nxt_st.ready = (nxt_st.ps == ckd_pkg::PS_RUN);

		// Register read data, zero for unmapped offsets
		if (reg_req.rd) begin
			case (reg_req.addr)
				ckd_pkg::OFS_ALIGN_CTRL: nxt_st.rdata = st_ff.align_ctrl;
				ckd_pkg::OFS_DIV_RATIO: nxt_st.rdata = {5'h00, st_ff.ratio_m1};
				ckd_pkg::OFS_DUTY_CTRL: nxt_st.rdata = st_ff.duty_ctrl;
				ckd_pkg::OFS_POWER_MODE: nxt_st.rdata = {6'h00, st_ff.power_mode};
				ckd_pkg::OFS_CLK_STATUS: nxt_st.rdata = status;
				default: nxt_st.rdata = 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.align_ctrl <= ckd_pkg::ALIGN_CTRL_RST;
			st_ff.ratio_m1 <= ckd_pkg::DIV_RATIO_RST;
			st_ff.duty_ctrl <= ckd_pkg::DUTY_CTRL_RST;
			st_ff.power_mode <= ckd_pkg::POWER_MODE_RST;
			st_ff.relock_cnt <= ckd_pkg::RELOCK_W'(RELOCK_N);
			st_ff.ps <= ckd_pkg::PS_RUN;
			st_ff.pwr <= '1;
			st_ff.ready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata = st_ff.rdata;
	assign pwr_ctl = st_ff.pwr;
	assign conv_ready = st_ff.ready;
	assign duty_cycle_restorer_locked = restorer_locked;

endmodule

`default_nettype wire

/* verilog/ckd_divider.sv */
/*
 * Integer clock divider with alignment reset and duty shaping.
 * Assumes ratio and control inputs come from logic on the same clock.
 */
`default_nettype none

module ckd_divider (
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] ratio_m1,
	input wire logic restore_on,
	input wire logic align,
	output logic conv_tick,
	output logic conv_clk
);

	typedef struct packed {
		logic [2:0] cnt;
		logic tick;
		logic lvl;
	} ckd_div_st_t;

	ckd_div_st_t st_ff;
	ckd_div_st_t nxt_st;
	logic [2:0] cnt_next;
	logic [3:0] high_len;

	always_comb begin
		nxt_st = st_ff;
		high_len = ({1'b0, ratio_m1} + 4'h2) >> 1;
		if (st_ff.cnt >= ratio_m1) begin
			cnt_next = 3'h0;
		end else begin
			cnt_next = st_ff.cnt + 3'h1;
		end
		if (!run) begin
			// Clock stopped: hold the initial state
			nxt_st = '0;
		end else if (align) begin
			// Period restarts on the accepted pulse
			nxt_st.cnt = 3'h0;
			nxt_st.tick = 1'b1;
			nxt_st.lvl = 1'b1;
		end else begin
			nxt_st.cnt = cnt_next;
			nxt_st.tick = (cnt_next == 3'h0);
			if (restore_on) begin
				// Rising edge kept, falling edge placed at half period
				// Level may rise only at period start, so a relock mid-period
				// never makes an extra sampling edge
				nxt_st.lvl = ({1'b0, cnt_next} < high_len) && ((cnt_next == 3'h0) || st_ff.lvl);
			end else begin
				// Bypassed: one raw input high phase per period
				nxt_st.lvl = (cnt_next == 3'h0);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign conv_tick = st_ff.tick;
	assign conv_clk = st_ff.lvl;

endmodule

`default_nettype wire

/* verilog/ckd_pkg.sv */
/*
 * Constants, encodings and carrier types shared by the clock divider and
 * power-state controller. Assumes a single 10 MHz input clock domain.
 */
`default_nettype none

package ckd_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam int REG_AW = 9;
	localparam logic [8:0] OFS_ALIGN_CTRL = 9'h100;
	localparam logic [8:0] OFS_DIV_RATIO = 9'h0F0;
	localparam logic [8:0] OFS_DUTY_CTRL = 9'h0F1;
	localparam logic [8:0] OFS_POWER_MODE = 9'h0F2;
	localparam logic [8:0] OFS_CLK_STATUS = 9'h0F3;

	// ------------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------------
	localparam int ALIGN_EN_BIT = 1;
	localparam int ALIGN_FIRST_BIT = 2;
	localparam int DUTY_EN_BIT = 0;
	localparam logic [7:0] ALIGN_CTRL_RST = 8'h00;
	localparam logic [2:0] DIV_RATIO_RST = 3'h0;
	localparam logic [7:0] DUTY_CTRL_RST = 8'h01;
	localparam logic [1:0] POWER_MODE_RST = 2'h0;
	localparam logic [1:0] PM_NORMAL = 2'h0;
	localparam logic [1:0] PM_DOWN = 2'h1;
	localparam logic [1:0] PM_STANDBY = 2'h2;

	// ------------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int RESTORER_MIN_HZ = 20_000_000;
	localparam int RELOCK_MIN_NS = 1500;
	localparam int RELOCK_CYC = (RELOCK_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int RELOCK_W = 8;
	localparam int DOWN_CNT_W = 16;
	localparam int WAKE_SHIFT_DOWN = 2;
	localparam int WAKE_SHIFT_STANDBY = 4;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic wr;
		logic rd;
		logic [REG_AW-1:0] addr;
		logic [7:0] wdata;
	} ckd_reg_req_t;

	typedef struct packed {
		logic ref_on;
		logic ref_buf_on;
		logic bias_on;
		logic clock_on;
		logic data_out_en;
	} ckd_pwr_ctl_t;

	typedef enum logic [1:0] {
		PS_RUN,
		PS_DOWN,
		PS_STANDBY,
		PS_WAKE
	} ckd_pwr_state_t;

endpackage

`default_nettype wire

/* verilog/ckd_sync.sv */
/*
 * Two-stage synchroniser for pin levels.
 * Assumes inputs are asynchronous to clk; only stage two is read outside.
 */
`default_nettype none

module ckd_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} ckd_sync_st_t;

	ckd_sync_st_t st_ff;
	ckd_sync_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = din;
		nxt_st.s2 = st_ff.s1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign dout = st_ff.s2;

endmodule

`default_nettype wire
